//--- src/gma_access_map.sv
// host address decode, relocation, memory arbiter and pin mapping
`timescale 1ns/1ps
// Functional notes
// - hold ready inactive until access completes
// - default first-family window map
// - second-family window map within 16 MB
// - bit0 at 005C relocates windows to top
// - relocated window map, memory up to 64MB
// - memory window is linear, SRAM-like
// - 16-bit pixel: blend alpha, 5-5-5 RGB
// - indirect pixel is one palette byte
// - depth unsigned, 8 or 16 bits
// - fill flag: one bit per pixel packed
// - texture 16-bit: stencil alpha, 5-5-5 RGB
// - capture stored 4:2:2 as Cb Y0 Cr Y1
// - 32-bit pixels host-written, alpha in bit31
// - frames up to 4096, multiple of 32
// - display fetch wraps at frame edges
// - layers two to five flip in blanking
// - fixed priority refresh capture display host drawing
// - row/col on pins below N, bank above
module gma_access_map #(
  parameter int ADDR_W = 26,
  parameter int MEM_AW = 24
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_HOST_CS_N,
  input wire logic I_HOST_RD_N,
  input wire logic I_HOST_WR_N,
  input wire logic I_BUS_FAMILY2,
  input wire logic [ADDR_W-1:0] I_HOST_ADDR,
  input wire logic [31:0] I_HOST_WDATA,
  input wire logic [3:0] I_HOST_BE_N,
  output logic [31:0] O_HOST_RDATA,
  output logic O_HOST_READY_N,
  output logic O_REGWIN_REQ,
  output logic [2:0] O_REGWIN_SEL,
  output logic [17:0] O_REGWIN_OFFSET,
  output logic O_REGWIN_WE,
  output logic [31:0] O_REGWIN_WDATA,
  output logic [3:0] O_REGWIN_BE,
  input wire logic I_REGWIN_ACK,
  input wire logic [31:0] I_REGWIN_RDATA,
  input wire logic [3:0] I_CLIENT_REQ,
  input wire logic [3:0] I_CLIENT_WE,
  input wire logic [MEM_AW-1:0] I_CAPTURE_ADDR,
  input wire logic [MEM_AW-1:0] I_DRAW_ADDR,
  input wire logic [11:0] I_DISP_X,
  input wire logic [11:0] I_DISP_Y,
  input wire logic [12:0] I_DISP_WIDTH,
  input wire logic [12:0] I_DISP_HEIGHT,
  input wire logic [7:0] I_DISP_STRIDE,
  input wire logic I_DISP_BPP16,
  input wire logic [MEM_AW+1:0] I_DISP_ORIGIN,
  input wire logic [MEM_AW+1:0] I_DISP_ORIGIN_ALT,
  input wire logic [1:0] I_DISP_LAYER_SEL,
  input wire logic I_VBLANK,
  input wire logic [3:0] I_FLIP_AUTO,
  input wire logic [3:0] I_FLIP_REQ,
  output logic [3:0] O_FRONT_SEL,
  output logic [3:0] O_CLIENT_DONE,
  output logic O_MEM_REQ,
  output logic O_MEM_WE,
  output logic O_MEM_REFRESH,
  output logic [MEM_AW-1:0] O_MEM_ADDR,
  output logic [3:0] O_MEM_BE,
  output logic [31:0] O_MEM_WDATA,
  input wire logic I_MEM_DONE,
  input wire logic [31:0] I_MEM_RDATA,
  input wire logic [3:0] I_MEMORY_MODE_CONFIG,
  output logic [gma_pkg::MA_WIDTH-1:0] O_MEMORY_ADDRESS_PINS_ROW,
  output logic [gma_pkg::MA_WIDTH-1:0] O_MEMORY_ADDRESS_PINS_COL,
  output logic O_RELOCATED
);
  typedef enum {HS_IDLE, HS_MEM, HS_REG, HS_DONE} gma_host_e;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    gma_host_e host_st;
    logic reloc;
    logic [2:0] win_sel;
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic ready_n;
    logic host_pend;
    logic mem_busy;
    logic [2:0] owner;
    logic mem_we;
    logic [MEM_AW-1:0] mem_addr;
    logic [gma_pkg::MA_WIDTH-1:0] ma_row;
    logic [gma_pkg::MA_WIDTH-1:0] ma_col;
    logic [3:0] client_done;
    logic regwin_req;
    logic [3:0] front_sel;
    logic [3:0] flip_pend;
  } gma_state_s;

  gma_state_s st_q;
  gma_state_s st_d;

  // decode a host byte address into a window
  function automatic gma_pkg::gma_win_e decode(input logic [ADDR_W-1:0] a, input logic fam2, input logic rel);
    logic [7:0] blk;
    blk = fam2 ? gma_pkg::BLK_FAM2 : (rel ? gma_pkg::BLK_RELOC : gma_pkg::BLK_FAM1);
    if (a[25:18] != blk)
      return gma_pkg::WIN_MEM;
    case (a[17:15])
      gma_pkg::SUB_HOSTIF0, gma_pkg::SUB_HOSTIF1: return gma_pkg::WIN_HOSTIF;
      gma_pkg::SUB_DISP: return gma_pkg::WIN_DISP;
      gma_pkg::SUB_CAPT: return gma_pkg::WIN_CAPT;
      gma_pkg::SUB_DRAW: return gma_pkg::WIN_DRAW;
      gma_pkg::SUB_GEOM: return gma_pkg::WIN_GEOM;
      default: return gma_pkg::WIN_NONE;
    endcase
  endfunction

  // split a word address into column, bank and row phases on the pins
  function automatic logic [2*gma_pkg::MA_WIDTH-1:0] map_pins(input logic [MEM_AW-1:0] wa, input logic [3:0] cfg);
    int n;
    int cw;
    logic [MEM_AW-1:0] rest;
    logic [gma_pkg::MA_WIDTH-1:0] row;
    logic [gma_pkg::MA_WIDTH-1:0] col;
    logic [1:0] bank;
    n = gma_pkg::MA_N_MIN + int'(cfg[1:0]);
    cw = gma_pkg::MA_COL_MIN + int'(cfg[3:2]);
    col = '0;
    row = '0;
    for (int i = 0; i < gma_pkg::MA_WIDTH; i++)
      if (i < cw)
        col[i] = wa[i];
    rest = wa >> cw;
    bank = rest[1:0];
    rest = rest >> 2;
    for (int i = 0; i < gma_pkg::MA_WIDTH; i++)
      if (i < n)
        row[i] = rest[i];
    row[n +: 2] = bank;
    col[n +: 2] = bank;
    return {row, col};
  endfunction

  // display fetch address with the frame treated as a torus
  function automatic logic [MEM_AW-1:0] disp_addr(input logic [MEM_AW+1:0] org);
    logic [12:0] x;
    logic [12:0] y;
    logic [MEM_AW+1:0] byte_a;
    x = {1'b0, I_DISP_X};
    y = {1'b0, I_DISP_Y};
    if (x >= I_DISP_WIDTH)
      x = x - I_DISP_WIDTH;
    if (y >= I_DISP_HEIGHT)
      y = y - I_DISP_HEIGHT;
    byte_a = org + (MEM_AW+2)'(I_DISP_BPP16 ? {x, 1'b0} : {1'b0, x})
      + (MEM_AW+2)'({I_DISP_STRIDE, 6'h00}) * (MEM_AW+2)'(y);
    return byte_a[MEM_AW+1:2];
  endfunction

  logic stable;
  logic strobe;
  logic [4:0] reqs;
  logic [2:0] pick;
  logic [MEM_AW+1:0] org;
  gma_pkg::gma_win_e win;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = {I_BUS_FAMILY2, I_HOST_WR_N, I_HOST_RD_N, I_HOST_CS_N};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.client_done = '0;
    st_d.regwin_req = 1'b0;
    stable = (st_q.s2 == st_q.s3);
    strobe = stable && !st_q.s3[0] && (!st_q.s3[1] || !st_q.s3[2]);
    win = decode(I_HOST_ADDR, st_q.s3[3], st_q.reloc);
    // host access sequencer: ready stays inactive until the data is settled
    case (st_q.host_st)
      HS_IDLE:
      begin
        st_d.ready_n = 1'b1;
        if (strobe)
        begin
          st_d.addr = I_HOST_ADDR;
          st_d.we = !st_q.s3[2];
          st_d.wdata = I_HOST_WDATA;
          st_d.be = ~I_HOST_BE_N;
          st_d.rdata = '0;
          case (win)
            gma_pkg::WIN_MEM:
            begin
              st_d.host_pend = 1'b1;
              st_d.host_st = HS_MEM;
            end
            gma_pkg::WIN_HOSTIF:
            begin
              if (I_HOST_ADDR[15:0] == gma_pkg::RLS_OFFSET)
              begin
                // relocation exists only for the first bus family
                if (!st_q.s3[2] && !st_q.s3[3] && !I_HOST_BE_N[0])
                  st_d.reloc = I_HOST_WDATA[0];
                st_d.rdata = {31'h0, st_q.reloc};
                st_d.host_st = HS_DONE;
              end
              else
              begin
                st_d.win_sel = 3'h0;
                st_d.regwin_req = 1'b1;
                st_d.host_st = HS_REG;
              end
            end
            gma_pkg::WIN_NONE: st_d.host_st = HS_DONE;
            default:
            begin
              st_d.win_sel = (win == gma_pkg::WIN_DISP) ? 3'h1 : (win == gma_pkg::WIN_CAPT) ? 3'h2
                : (win == gma_pkg::WIN_DRAW) ? 3'h3 : 3'h4;
              st_d.regwin_req = 1'b1;
              st_d.host_st = HS_REG;
            end
          endcase
        end
      end
      HS_REG:
        if (I_REGWIN_ACK)
        begin
          st_d.rdata = I_REGWIN_RDATA;
          st_d.host_st = HS_DONE;
        end
      HS_MEM: ;
      HS_DONE:
      begin
        // ready held until the host drops its strobes
        st_d.ready_n = 1'b0;
        if (stable && (st_q.s3[0] || (st_q.s3[1] && st_q.s3[2])))
        begin
          st_d.ready_n = 1'b1;
          st_d.host_st = HS_IDLE;
        end
      end
      default: st_d.host_st = HS_IDLE;
    endcase
    // arbiter: a new owner is chosen only once the running access is done
    reqs = {I_CLIENT_REQ[3], st_q.host_pend, I_CLIENT_REQ[2:0]};
    pick = 3'h0;
    for (int i = gma_pkg::REQ_DRAW; i >= gma_pkg::REQ_REFRESH; i--)
      if (reqs[i])
        pick = 3'(i);
    org = st_q.front_sel[I_DISP_LAYER_SEL] ? I_DISP_ORIGIN_ALT : I_DISP_ORIGIN;
    if (st_q.mem_busy)
    begin
      if (I_MEM_DONE)
      begin
        st_d.mem_busy = 1'b0;
        if (st_q.owner == 3'(gma_pkg::REQ_HOST))
        begin
          st_d.host_pend = 1'b0;
          st_d.rdata = st_q.we ? 32'h0 : I_MEM_RDATA;
          st_d.host_st = HS_DONE;
        end
        else if (st_q.owner == 3'(gma_pkg::REQ_DRAW))
          st_d.client_done[3] = 1'b1;
        else
          st_d.client_done[st_q.owner[1:0]] = 1'b1;
      end
    end
    else if (|reqs)
    begin
      st_d.mem_busy = 1'b1;
      st_d.owner = pick;
      case (pick)
        3'(gma_pkg::REQ_REFRESH):
        begin
          st_d.mem_addr = '0;
          st_d.mem_we = 1'b0;
        end
        3'(gma_pkg::REQ_CAPTURE):
        begin
          st_d.mem_addr = I_CAPTURE_ADDR;
          st_d.mem_we = I_CLIENT_WE[1];
        end
        3'(gma_pkg::REQ_DISPLAY):
        begin
          st_d.mem_addr = disp_addr(org);
          st_d.mem_we = 1'b0;
        end
        3'(gma_pkg::REQ_HOST):
        begin
          st_d.mem_addr = st_q.addr[MEM_AW+1:2];
          st_d.mem_we = st_q.we;
        end
        default:
        begin
          st_d.mem_addr = I_DRAW_ADDR;
          st_d.mem_we = I_CLIENT_WE[3];
        end
      endcase
      {st_d.ma_row, st_d.ma_col} = map_pins(st_d.mem_addr, I_MEMORY_MODE_CONFIG);
    end
    // frame flips for layers two to five, only inside blanking
    st_d.flip_pend = st_q.flip_pend | I_FLIP_REQ;
    if (I_VBLANK)
    begin
      st_d.front_sel = st_q.front_sel ^ (I_FLIP_AUTO | st_q.flip_pend);
      st_d.flip_pend = I_FLIP_REQ;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      st_q <= '0;
      st_q.s1 <= 4'hF;
      st_q.s2 <= 4'hF;
      st_q.s3 <= 4'hF;
      st_q.host_st <= HS_IDLE;
      st_q.reloc <= gma_pkg::RLS_RESET;
      st_q.ready_n <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign O_HOST_RDATA = st_q.rdata;
  assign O_HOST_READY_N = st_q.ready_n;
  assign O_REGWIN_REQ = st_q.regwin_req;
  assign O_REGWIN_SEL = st_q.win_sel;
  assign O_REGWIN_OFFSET = st_q.addr[17:0];
  assign O_REGWIN_WE = st_q.we;
  assign O_REGWIN_WDATA = st_q.wdata;
  assign O_REGWIN_BE = st_q.be;
  assign O_FRONT_SEL = st_q.front_sel;
  assign O_CLIENT_DONE = st_q.client_done;
  assign O_MEM_REQ = st_q.mem_busy;
  assign O_MEM_WE = st_q.mem_we;
  assign O_MEM_REFRESH = st_q.mem_busy && (st_q.owner == 3'(gma_pkg::REQ_REFRESH));
  assign O_MEM_ADDR = st_q.mem_addr;
  assign O_MEM_BE = st_q.be;
  assign O_MEM_WDATA = st_q.wdata;
  assign O_MEMORY_ADDRESS_PINS_ROW = st_q.ma_row;
  assign O_MEMORY_ADDRESS_PINS_COL = st_q.ma_col;
  assign O_RELOCATED = st_q.reloc;
endmodule // gma_access_map

//--- shared/gma_pkg.sv
// constants, types and format helpers for the graphics memory access map
package gma_pkg;
  localparam logic [7:0] BLK_FAM1 = 8'h7F; // 256 KB register block at 01FC0000
  localparam logic [7:0] BLK_RELOC = 8'hFF; // block at 03FC0000
  localparam logic [7:0] BLK_FAM2 = 8'h3F; // block at 00FC0000
  localparam logic [2:0] SUB_HOSTIF0 = 3'h0;
  localparam logic [2:0] SUB_HOSTIF1 = 3'h1;
  localparam logic [2:0] SUB_DISP = 3'h2; // +10000
  localparam logic [2:0] SUB_CAPT = 3'h3; // +18000
  localparam logic [2:0] SUB_DRAW = 3'h6; // +30000
  localparam logic [2:0] SUB_GEOM = 3'h7; // +38000
  localparam logic [15:0] RLS_OFFSET = 16'h005C;
  localparam logic RLS_RESET = 1'b0;
  localparam int REQ_REFRESH = 0;
  localparam int REQ_CAPTURE = 1;
  localparam int REQ_DISPLAY = 2;
  localparam int REQ_HOST = 3;
  localparam int REQ_DRAW = 4;
  localparam int MAX_FRAME = 4096;
  localparam int FRAME_UNIT = 32;
  localparam int MA_N_MIN = 11;
  localparam int MA_COL_MIN = 8;
  localparam int MA_WIDTH = 15;

  typedef enum {WIN_MEM, WIN_HOSTIF, WIN_DISP, WIN_CAPT, WIN_DRAW, WIN_GEOM, WIN_NONE} gma_win_e;

  typedef struct packed {logic alpha; logic [4:0] red; logic [4:0] green; logic [4:0] blue;} gma_pix16_s;
  typedef struct packed {logic alpha; logic [6:0] rsvd; logic [7:0] red; logic [7:0] green; logic [7:0] blue;} gma_pix32_s;
  typedef struct packed {logic [7:0] y1; logic [7:0] cr; logic [7:0] y0; logic [7:0] cb;} gma_ycc_pair_s;
  typedef logic [7:0] gma_index_t;

  // alpha of 16-bit display pixels is the layer-blend flag
  function automatic logic blend_flag16(input gma_pix16_s p);
    return p.alpha;
  endfunction

  // alpha of 16-bit texture/tile pixels is the stencil flag
  function automatic logic stencil_flag16(input gma_pix16_s p);
    return p.alpha;
  endfunction

  // 32-bit layers are host-written only, the drawing engine never makes them
  function automatic logic blend_flag32(input gma_pix32_s p);
    return p.alpha;
  endfunction

  // palette index for layer or cursor pixels
  function automatic gma_index_t palette_index(input logic [31:0] w, input logic [1:0] lane);
    return w[8*lane +: 8];
  endfunction

  // depth bytes per pixel, unsigned
  function automatic logic [1:0] depth_bytes(input logic depth16);
    return depth16 ? 2'h2 : 2'h1;
  endfunction

  // fill flag of pixel x: word x/32, bit x%32
  function automatic logic flag_bit(input logic [31:0] w, input logic [11:0] x);
    return w[x[4:0]];
  endfunction

  // frame dims must be a multiple of 32 and at most 4096
  function automatic logic frame_ok(input logic [12:0] w, input logic [12:0] h);
    return (w <= 13'(MAX_FRAME)) && (h <= 13'(MAX_FRAME)) && (w[4:0] == 5'h0) && (h[4:0] == 5'h0);
  endfunction
endpackage

//--- verification/gma_access_map_assertions.sv
// concurrent checks on the access map ports
`timescale 1ns/1ps
module gma_access_map_assertions #(
  parameter int ADDR_W = 26,
  parameter int MEM_AW = 24
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_HOST_CS_N,
  input wire logic I_HOST_WR_N,
  input wire logic [31:0] I_HOST_WDATA,
  input wire logic [3:0] I_HOST_BE_N,
  input wire logic I_BUS_FAMILY2,
  input wire logic [3:0] I_CLIENT_REQ,
  input wire logic [MEM_AW-1:0] I_CAPTURE_ADDR,
  input wire logic I_MEM_DONE,
  input wire logic I_VBLANK,
  input wire logic O_HOST_READY_N,
  input wire logic O_REGWIN_REQ,
  input wire logic O_MEM_REQ,
  input wire logic O_MEM_REFRESH,
  input wire logic [MEM_AW-1:0] O_MEM_ADDR,
  input wire logic [3:0] O_CLIENT_DONE,
  input wire logic O_RELOCATED,
  input wire logic [3:0] O_FRONT_SEL
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  // strobes pass a three-stage synchroniser before they count
  a_ready_late: assert property ($fell(I_HOST_CS_N) |-> O_HOST_READY_N [*3])
    else $error("ready given before the strobe was synchronised");
  a_ready_hold: assert property (!O_HOST_READY_N && !I_HOST_CS_N |=> !O_HOST_READY_N)
    else $error("ready dropped while the host still selects");
  a_regwin_wait: assert property (O_REGWIN_REQ |-> O_HOST_READY_N)
    else $error("ready given before the window answered");
  a_mem_hold: assert property (O_MEM_REQ && !I_MEM_DONE |=> O_MEM_REQ && $stable(O_MEM_ADDR))
    else $error("memory access cut short or address moved");
  a_mem_gap: assert property (O_MEM_REQ && I_MEM_DONE |=> !O_MEM_REQ)
    else $error("no idle cycle after a memory access");
  a_client_done: assert property (O_CLIENT_DONE != 4'h0 |-> $past(O_MEM_REQ && I_MEM_DONE))
    else $error("client done without a finished access");
  a_refresh_first: assert property (!O_MEM_REQ && !$past(O_MEM_REQ) && I_CLIENT_REQ[0] |=> O_MEM_REQ && O_MEM_REFRESH)
    else $error("refresh not granted first");
  a_capture_next: assert property (!O_MEM_REQ && I_CLIENT_REQ[1:0] == 2'h2
    |=> O_MEM_REQ && !O_MEM_REFRESH && O_MEM_ADDR == $past(I_CAPTURE_ADDR))
    else $error("capture not granted ahead of the rest");
  a_reloc_write: assert property ($rose(O_RELOCATED)
    |-> !I_BUS_FAMILY2 && !I_HOST_WR_N && !I_HOST_BE_N[0] && I_HOST_WDATA[0])
    else $error("relocation without a valid write");
  a_flip_blank: assert property ($changed(O_FRONT_SEL) |-> $past(I_VBLANK))
    else $error("frame flip outside blanking");
endmodule // gma_access_map_assertions

bind gma_access_map gma_access_map_assertions #(.ADDR_W(ADDR_W), .MEM_AW(MEM_AW)) u_chk (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_HOST_CS_N(I_HOST_CS_N), .I_HOST_WR_N(I_HOST_WR_N),
  .I_HOST_WDATA(I_HOST_WDATA), .I_HOST_BE_N(I_HOST_BE_N), .I_BUS_FAMILY2(I_BUS_FAMILY2),
  .I_CLIENT_REQ(I_CLIENT_REQ), .I_CAPTURE_ADDR(I_CAPTURE_ADDR), .I_MEM_DONE(I_MEM_DONE),
  .I_VBLANK(I_VBLANK), .O_HOST_READY_N(O_HOST_READY_N), .O_REGWIN_REQ(O_REGWIN_REQ),
  .O_MEM_REQ(O_MEM_REQ), .O_MEM_REFRESH(O_MEM_REFRESH), .O_MEM_ADDR(O_MEM_ADDR),
  .O_CLIENT_DONE(O_CLIENT_DONE), .O_RELOCATED(O_RELOCATED), .O_FRONT_SEL(O_FRONT_SEL));

//--- verification/gma_far_model.sv
// memory and register window model on the far side
`timescale 1ns/1ps
module gma_far_model (
  input wire logic i_clk,
  input wire logic [1:0] i_lat,
  input wire logic i_mem_req,
  input wire logic [23:0] i_mem_addr,
  output logic o_mem_done,
  output logic [31:0] o_mem_rdata,
  input wire logic i_win_req,
  input wire logic [2:0] i_win_sel,
  input wire logic [17:0] i_win_off,
  output logic o_win_ack,
  output logic [31:0] o_win_rdata
);
  logic [1:0] cnt = 2'h0;
  initial o_mem_done = 1'b0;
  initial o_win_ack = 1'b0;
  initial o_mem_rdata = 32'h0;
  initial o_win_rdata = 32'h0;
  // released data toggles so a late sample can never look right
  always @(posedge i_clk)
  begin
    o_mem_done <= 1'b0;
    o_win_ack <= i_win_req;
    o_win_rdata <= i_win_req ? {11'h0, i_win_sel, i_win_off} : ~o_win_rdata;
    if (i_mem_req && !o_mem_done)
    begin
      cnt <= (cnt == i_lat) ? 2'h0 : cnt + 2'h1;
      o_mem_done <= (cnt == i_lat);
      o_mem_rdata <= {8'h5A, i_mem_addr};
    end
    else if (!i_mem_req)
      o_mem_rdata <= ~o_mem_rdata;
  end
endmodule // gma_far_model

//--- verification/gma_access_map_tb.sv
// self-checking bench for the graphics memory access map
`timescale 1ns/1ps
module gma_access_map_tb;
  logic clk, srst, rdy_n, wreq, wwe, mreq, mwe, mref, rel, wack, mdone;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, fam2 = 1'b0, vbl = 1'b0, bpp = 1'b0;
  logic [25:0] ha = 26'h0, org = 26'h0, orga = 26'h100;
  logic [31:0] hwd = 32'h0, rdat, wwd, mwd, mrd, wrd, q, m_wd;
  logic [3:0] be_n = 4'h0, creq = 4'h0, cwe = 4'h0, fauto = 4'h0, freq = 4'h0, mmc = 4'h0;
  logic [3:0] fsel, cdone, wbe, mbe;
  logic [23:0] caddr = 24'h00ABC4, daddr = 24'h0, maddr, m_addr;
  logic [11:0] dx = 12'h0, dy = 12'h0;
  logic [12:0] dw = 13'h40, dh = 13'h40;
  logic [7:0] stride = 8'h1;
  logic [1:0] lsel = 2'h0, lat = 2'h0;
  logic [2:0] wsel, w_sel;
  logic [17:0] woff;
  logic [14:0] prow, pcol;
  logic [17:0] offs [5] = '{18'h00100, 18'h10000, 18'h18000, 18'h30000, 18'h38000};
  int bad_count, checks;

  gma_access_map u_dut (.I_CLK(clk), .I_SRST(srst), .I_HOST_CS_N(cs_n), .I_HOST_RD_N(rd_n),
    .I_HOST_WR_N(wr_n), .I_BUS_FAMILY2(fam2), .I_HOST_ADDR(ha), .I_HOST_WDATA(hwd), .I_HOST_BE_N(be_n),
    .O_HOST_RDATA(rdat), .O_HOST_READY_N(rdy_n), .O_REGWIN_REQ(wreq), .O_REGWIN_SEL(wsel),
    .O_REGWIN_OFFSET(woff), .O_REGWIN_WE(wwe), .O_REGWIN_WDATA(wwd), .O_REGWIN_BE(wbe),
    .I_REGWIN_ACK(wack), .I_REGWIN_RDATA(wrd), .I_CLIENT_REQ(creq), .I_CLIENT_WE(cwe),
    .I_CAPTURE_ADDR(caddr), .I_DRAW_ADDR(daddr), .I_DISP_X(dx), .I_DISP_Y(dy), .I_DISP_WIDTH(dw),
    .I_DISP_HEIGHT(dh), .I_DISP_STRIDE(stride), .I_DISP_BPP16(bpp), .I_DISP_ORIGIN(org),
    .I_DISP_ORIGIN_ALT(orga), .I_DISP_LAYER_SEL(lsel), .I_VBLANK(vbl), .I_FLIP_AUTO(fauto),
    .I_FLIP_REQ(freq), .O_FRONT_SEL(fsel), .O_CLIENT_DONE(cdone), .O_MEM_REQ(mreq), .O_MEM_WE(mwe),
    .O_MEM_REFRESH(mref), .O_MEM_ADDR(maddr), .O_MEM_BE(mbe), .O_MEM_WDATA(mwd), .I_MEM_DONE(mdone),
    .I_MEM_RDATA(mrd), .I_MEMORY_MODE_CONFIG(mmc), .O_MEMORY_ADDRESS_PINS_ROW(prow),
    .O_MEMORY_ADDRESS_PINS_COL(pcol), .O_RELOCATED(rel));

  gma_far_model u_far (.i_clk(clk), .i_lat(lat), .i_mem_req(mreq), .i_mem_addr(maddr), .o_mem_done(mdone),
    .o_mem_rdata(mrd), .i_win_req(wreq), .i_win_sel(wsel), .i_win_off(woff), .o_win_ack(wack),
    .o_win_rdata(wrd));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (wreq) w_sel <= wsel;
  always @(posedge clk) if (mreq) m_addr <= maddr;
  always @(posedge clk) if (mreq) m_wd <= mwd;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait for the ready line to reach a level
  task automatic waitfor(input logic v);
    int n;
    n = 0;
    while (rdy_n !== v && n < 100)
    begin
      tick(1);
      n++;
    end
    chk("ready level", 32'(v), 32'(rdy_n));
    if (n == 100)
      tally_and_finish();
  endtask

  // one host cycle: strobes held until the edge that sees ready low
  task automatic acc(input logic we, input logic [25:0] a, input logic [31:0] d);
    ha = a;
    hwd = d;
    rd_n = we;
    wr_n = !we;
    cs_n = 1'b0;
    tick(3);
    waitfor(1'b0);
    q = rdat;
    tick(1);
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    waitfor(1'b1);
  endtask

  task automatic rst(input logic f);
    fam2 = f;
    srst = 1'b1;
    tick(16);
    srst = 1'b0;
    tick(4);
    chk("ready after reset", 32'h1, 32'(rdy_n));
  endtask

  // every window of one block, the unmapped gap and the relocation bit
  task automatic t_map(input logic [7:0] blk, input logic r);
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b0, {blk, offs[i]}, 32'h0);
      chk("window select", 32'(i), 32'(w_sel));
    end
    acc(1'b0, {blk, 18'h20000}, 32'h0);
    chk("unmapped read", 32'h0, q);
    acc(1'b0, {blk, 18'h0005C}, 32'h0);
    chk("relocation bit", 32'(r), q);
    $display("window map of block %h done", blk);
  endtask

  task automatic t_mem();
    lat = 2'h2;
    acc(1'b1, 26'h0001238, 32'hCAFE0001);
    chk("write address", 32'h48E, 32'(m_addr));
    chk("write data", 32'hCAFE0001, m_wd);
    acc(1'b0, 26'h0001238, 32'h0);
    chk("read data", 32'h5A00048E, q);
    chk("row pins", 32'h1, 32'(prow));
    chk("column pins", 32'h8E, 32'(pcol));
    acc(1'b1, 26'h0002000, 32'h0);
    chk("clear address", 32'h800, 32'(m_addr));
    $display("memory access done");
  endtask

  // all clients at once: done pulses must come in priority order
  task automatic t_prio();
    int n;
    lat = 2'h1;
    creq = 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      n = 0;
      while (cdone === 4'h0 && n < 50)
      begin
        tick(1);
        n++;
      end
      chk("grant order", 32'h1 << i, 32'(cdone));
      if (i == 1)
        chk("capture address", 32'(caddr), 32'(m_addr));
      if (n == 50)
        tally_and_finish();
      creq[i] = 1'b0;
      tick(1);
    end
    $display("arbitration done");
  endtask

  task automatic t_flip();
    fauto = 4'h1;
    freq = 4'h2;
    tick(1);
    freq = 4'h0;
    tick(3);
    chk("front before blank", 32'h0, 32'(fsel));
    vbl = 1'b1;
    tick(1);
    vbl = 1'b0;
    tick(2);
    chk("front after flip", 32'h3, 32'(fsel));
    vbl = 1'b1;
    tick(1);
    vbl = 1'b0;
    tick(2);
    chk("front auto only", 32'h2, 32'(fsel));
    $display("frame flip done");
  endtask

  initial
  begin
    rst(1'b0);
    t_map(8'h7F, 1'b0);
    t_mem();
    acc(1'b1, 26'h1FC005C, 32'h1);
    tick(20);
    chk("relocated", 32'h1, 32'(rel));
    t_map(8'hFF, 1'b1);
    acc(1'b0, 26'h1FC0000, 32'h0);
    chk("old block is memory", 32'h7F0000, 32'(m_addr));
    t_prio();
    t_flip();
    rst(1'b1);
    t_map(8'h3F, 1'b0);
    acc(1'b1, 26'h0FC005C, 32'h1);
    tick(20);
    chk("relocation refused", 32'h0, 32'(rel));
    tally_and_finish();
  end
endmodule // gma_access_map_tb
